/* rtl/rsc_top.sv */
// Operation
// - A second notch with zero depth is off, frequency and depth alike.
// - A third notch with zero depth is off, frequency and depth alike.
// - The third notch frequency takes 50 to 2000 Hz, resets to 1000, and zero turns it off.
// - The low-pass time constant takes 0 to 1000 in 0.1 ms steps, and zero turns it off.
// - The low-pass time constant resets to 2 on small models and 5 on larger ones.
// - Each notch depth is a 16-bit value from 0 to 32 dB that resets to 0.
// - Auto modes 1 and 2 search for resonance and store found frequencies and depths.
// - Auto mode 1 returns to 0 by itself once the mechanics have settled for 20 minutes.
// - Auto mode 2 keeps searching without end.
// - Writing 1 from any mode, or 2 from mode 0, clears the four notch settings and searches.
// - Writing 2 while in mode 1 or 2 keeps the notch settings and keeps searching.
// - Writing 0 while in mode 1 or 2 keeps the notch settings and stops searching.
// - A nonzero depth marks a frequency found by the search, zero marks the default 1000.
`include "rsc_map.svh"
`default_nettype none
module rsc_top
  import rsc_pkg::*;
#(
  parameter int TICK_CYC = `RSC_TICK_CYC,
  parameter int WINDOW_TICKS = `RSC_WINDOW_TICKS,
  parameter int SETTLE_WIN = `RSC_SETTLE_WIN,
  parameter logic [15:0] PEAK_LIMIT = 16'h1000
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HIGH_POWER_MODEL,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_IN,
  output logic SAMPLE_OUT_VALID,
  output logic [15:0] SAMPLE_OUT
);
  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 65535) $error("TICK_CYC out of range");
    if (WINDOW_TICKS < 2 || WINDOW_TICKS > 65535) $error("WINDOW_TICKS out of range");
    if (SETTLE_WIN < 1 || SETTLE_WIN > 65535) $error("SETTLE_WIN out of range");
  end

  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    byte_addr = 12'(idx << 2);
  endfunction

  function automatic logic [15:0] clamp_freq(input logic [15:0] v);
    if (v == 16'h0000) clamp_freq = 16'h0000;
    else if (v < `RSC_FREQ_MIN) clamp_freq = `RSC_FREQ_MIN;
    else if (v > `RSC_FREQ_MAX) clamp_freq = `RSC_FREQ_MAX;
    else clamp_freq = v;
  endfunction

  function automatic logic [15:0] clamp_max(input logic [15:0] v, input logic [15:0] m);
    clamp_max = (v > m) ? m : v;
  endfunction

  // shift of a first-order section: larger low-pass time, slower section; higher notch frequency, faster section
  function automatic logic [3:0] msb_pos(input logic [15:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) p = 4'(i);
    end
    msb_pos = p;
  endfunction

  function automatic logic [3:0] lp_shift(input logic [15:0] t);
    lp_shift = (msb_pos(t) > 4'hB) ? 4'hC : msb_pos(t) + 4'h1;
  endfunction

  function automatic logic [3:0] notch_shift(input logic [15:0] f);
    notch_shift = (msb_pos(f) > 4'hA) ? 4'h1 : 4'hC - msb_pos(f);
  endfunction

  // strap synchroniser and post-reset load of the model-dependent default
  logic strap_meta;
  logic strap_sync;
  logic [1:0] init_cnt;
  wire logic init_load = (init_cnt == 2'h2);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      init_cnt <= 2'h0;
    end else begin
      strap_meta <= HIGH_POWER_MODEL;
      strap_sync <= strap_meta;
      if (init_cnt != 2'h3) init_cnt <= init_cnt + 2'h1;
    end
  end

  // registers
  logic [15:0] lowpass_time;
  logic [15:0] notch_two_frequency;
  logic [15:0] notch_two_depth;
  logic [15:0] notch_three_frequency;
  logic [15:0] notch_three_depth;
  rsc_mode_t auto_resonance_mode;

  // APB decode, zero wait states
  wire logic wr_en = PSEL & PENABLE & PWRITE;
  wire logic hit_lp = (PADDR == byte_addr(`RSC_IDX_LOWPASS));
  wire logic hit_n2f = (PADDR == byte_addr(`RSC_IDX_N2_FREQ));
  wire logic hit_n2d = (PADDR == byte_addr(`RSC_IDX_N2_DEPTH));
  wire logic hit_n3f = (PADDR == byte_addr(`RSC_IDX_N3_FREQ));
  wire logic hit_n3d = (PADDR == byte_addr(`RSC_IDX_N3_DEPTH));
  wire logic hit_mode = (PADDR == byte_addr(`RSC_IDX_AUTO_MODE));
  wire logic hit_st = (PADDR == byte_addr(`RSC_IDX_STATUS));
  wire logic hit_any = hit_lp | hit_n2f | hit_n2d | hit_n3f | hit_n3d | hit_mode | hit_st;
  wire logic [15:0] wr16 = PWDATA[15:0];
  wire logic mode_wr = wr_en & hit_mode & (wr16 <= 16'h0002);
  wire logic mode_active = (auto_resonance_mode != RSC_MODE_OFF);
  wire logic clear_notches = mode_wr &
    ((wr16 == 16'h0001) | ((wr16 == 16'h0002) & ~mode_active));

  // filter enables
  wire logic n2_on = (notch_two_depth != 16'h0000) & (notch_two_frequency != 16'h0000);
  wire logic n3_on = (notch_three_depth != 16'h0000) & (notch_three_frequency != 16'h0000);
  wire logic lp_on = (lowpass_time != 16'h0000);
  wire logic at_max = (notch_two_depth == `RSC_DEPTH_MAX) | (notch_three_depth == `RSC_DEPTH_MAX);

  wire logic [15:0] status = {11'h000, lp_on, at_max, n3_on, n2_on, mode_active};
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & (~hit_any | (PWRITE & hit_st));
  assign PRDATA = {16'h0000,
    hit_lp ? lowpass_time :
    hit_n2f ? notch_two_frequency :
    hit_n2d ? notch_two_depth :
    hit_n3f ? notch_three_frequency :
    hit_n3d ? notch_three_depth :
    hit_mode ? {14'h0000, auto_resonance_mode} :
    hit_st ? status : 16'h0000};

  // search engine: tick divider, zero-crossing count, peak tracking
  rsc_srch_t srch;
  logic [15:0] tick_cnt;
  logic [15:0] win_cnt;
  logic [15:0] settle_cnt;
  logic [15:0] crossings;
  logic [15:0] peak;
  logic [15:0] held;
  logic last_sign;
  logic [15:0] found_freq;
  wire logic tick = (tick_cnt == 16'(TICK_CYC - 1));
  wire logic win_end = tick & (win_cnt == 16'(WINDOW_TICKS - 1));
  wire logic [15:0] mag = held[15] ? 16'(-held) : held;
  wire logic [15:0] meas_freq = {1'b0, crossings[15:1]};
  wire logic found = (peak > PEAK_LIMIT) & (meas_freq >= `RSC_FREQ_MIN) &
                     (meas_freq <= `RSC_FREQ_MAX);
  wire logic [15:0] d2 = (meas_freq > notch_two_frequency) ?
    meas_freq - notch_two_frequency : notch_two_frequency - meas_freq;
  wire logic [15:0] d3 = (meas_freq > notch_three_frequency) ?
    meas_freq - notch_three_frequency : notch_three_frequency - meas_freq;
  wire logic use_n2 = (notch_two_depth == 16'h0000) | (d2 <= `RSC_FREQ_SAME) |
    ((notch_three_depth != 16'h0000) & (d3 > `RSC_FREQ_SAME));
  wire logic apply = (srch == RSC_SRCH_APPLY);
  wire logic settled = (auto_resonance_mode == RSC_MODE_ONCE) &
                       (settle_cnt == 16'(SETTLE_WIN)) & win_end;
  wire logic [15:0] n2_step = clamp_max(notch_two_depth + `RSC_DEPTH_STEP, `RSC_DEPTH_MAX);
  wire logic [15:0] n3_step = clamp_max(notch_three_depth + `RSC_DEPTH_STEP, `RSC_DEPTH_MAX);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      held <= 16'h0000;
      tick_cnt <= 16'h0000;
    end else begin
      if (SAMPLE_VALID) held <= SAMPLE_IN;
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      srch <= RSC_SRCH_IDLE;
      win_cnt <= 16'h0000;
      crossings <= 16'h0000;
      peak <= 16'h0000;
      last_sign <= 1'b0;
      settle_cnt <= 16'h0000;
      found_freq <= 16'h0000;
    end else begin
      case (srch)
        RSC_SRCH_IDLE: begin
          win_cnt <= 16'h0000;
          crossings <= 16'h0000;
          peak <= 16'h0000;
          settle_cnt <= 16'h0000;
          if (mode_active) srch <= RSC_SRCH_MEASURE;
        end
        RSC_SRCH_MEASURE: begin
          if (!mode_active || clear_notches) begin
            srch <= RSC_SRCH_IDLE;
          end else if (tick) begin
            last_sign <= held[15];
            if (held[15] != last_sign) crossings <= crossings + 16'h0001;
            if (mag > peak) peak <= mag;
            win_cnt <= win_end ? 16'h0000 : win_cnt + 16'h0001;
            if (win_end) begin
              found_freq <= meas_freq;
              if (found) begin
                settle_cnt <= 16'h0000;
                srch <= RSC_SRCH_APPLY;
              end else begin
                crossings <= 16'h0000;
                peak <= 16'h0000;
                if (settle_cnt != 16'(SETTLE_WIN)) settle_cnt <= settle_cnt + 16'h0001;
              end
            end
          end
        end
        RSC_SRCH_APPLY: begin
          crossings <= 16'h0000;
          peak <= 16'h0000;
          srch <= mode_active ? RSC_SRCH_MEASURE : RSC_SRCH_IDLE;
        end
        default: srch <= RSC_SRCH_IDLE;
      endcase
    end
  end

  // register writes; software access wins over a search update in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lowpass_time <= `RSC_LP_LOW_POWER;
      notch_two_frequency <= `RSC_FREQ_DEFAULT;
      notch_two_depth <= `RSC_DEPTH_DEFAULT;
      notch_three_frequency <= `RSC_FREQ_DEFAULT;
      notch_three_depth <= `RSC_DEPTH_DEFAULT;
      auto_resonance_mode <= RSC_MODE_OFF;
    end else begin
      if (init_load && strap_sync) lowpass_time <= `RSC_LP_HIGH_POWER;
      if (wr_en && hit_lp) lowpass_time <= clamp_max(wr16, `RSC_LP_MAX);
      if (clear_notches) begin
        // cleared depth marks the frequency as not found
        notch_two_frequency <= `RSC_FREQ_DEFAULT;
        notch_two_depth <= 16'h0000;
        notch_three_frequency <= `RSC_FREQ_DEFAULT;
        notch_three_depth <= 16'h0000;
      end else if (wr_en && (hit_n2f || hit_n2d || hit_n3f || hit_n3d)) begin
        if (hit_n2f) notch_two_frequency <= clamp_freq(wr16);
        if (hit_n2d) notch_two_depth <= clamp_max(wr16, `RSC_DEPTH_MAX);
        if (hit_n3f) notch_three_frequency <= clamp_freq(wr16);
        if (hit_n3d) notch_three_depth <= clamp_max(wr16, `RSC_DEPTH_MAX);
      end else if (apply && mode_active) begin
        // a found resonance lands in a notch with a nonzero depth
        if (use_n2) begin
          notch_two_frequency <= found_freq;
          notch_two_depth <= n2_step;
        end else begin
          notch_three_frequency <= found_freq;
          notch_three_depth <= n3_step;
        end
      end
      if (mode_wr) begin
        auto_resonance_mode <= rsc_mode_t'(wr16[1:0]);
      end else if (settled) begin
        auto_resonance_mode <= RSC_MODE_OFF;
      end
    end
  end

  // filter chain: low-pass, second notch, third notch
  logic v1;
  logic v2;
  logic [15:0] s1;
  logic [15:0] s2;

  rsc_stage u_lowpass (
    .clk(CLK),
    .rst(RST),
    .enable(lp_on),
    .is_notch(1'b0),
    .shift(lp_shift(lowpass_time)),
    .depth(6'h00),
    .in_valid(SAMPLE_VALID),
    .in_data(SAMPLE_IN),
    .out_valid(v1),
    .out_data(s1)
  );

  rsc_stage u_notch_two (
    .clk(CLK),
    .rst(RST),
    .enable(n2_on),
    .is_notch(1'b1),
    .shift(notch_shift(notch_two_frequency)),
    .depth(notch_two_depth[5:0]),
    .in_valid(v1),
    .in_data(s1),
    .out_valid(v2),
    .out_data(s2)
  );

  rsc_stage u_notch_three (
    .clk(CLK),
    .rst(RST),
    .enable(n3_on),
    .is_notch(1'b1),
    .shift(notch_shift(notch_three_frequency)),
    .depth(notch_three_depth[5:0]),
    .in_valid(v2),
    .in_data(s2),
    .out_valid(SAMPLE_OUT_VALID),
    .out_data(SAMPLE_OUT)
  );
endmodule
`default_nettype wire

/* include/rsc_map.svh */
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// register indices; byte address is four times the index
`define RSC_IDX_LOWPASS 12'h232
`define RSC_IDX_N2_FREQ 12'h256
`define RSC_IDX_N2_DEPTH 12'h258
`define RSC_IDX_N3_FREQ 12'h25A
`define RSC_IDX_N3_DEPTH 12'h25C
`define RSC_IDX_AUTO_MODE 12'h25E
`define RSC_IDX_STATUS 12'h260
// reset values
`define RSC_FREQ_DEFAULT 16'h03E8
`define RSC_DEPTH_DEFAULT 16'h0000
`define RSC_LP_LOW_POWER 16'h0002
`define RSC_LP_HIGH_POWER 16'h0005
// ranges
`define RSC_FREQ_MIN 16'h0032
`define RSC_FREQ_MAX 16'h07D0
`define RSC_DEPTH_MAX 16'h0020
`define RSC_LP_MAX 16'h03E8
`define RSC_DEPTH_STEP 16'h0002
`define RSC_FREQ_SAME 16'h0019
// status bits
`define RSC_ST_SEARCH 0
`define RSC_ST_N2_ON 1
`define RSC_ST_N3_ON 2
`define RSC_ST_AT_MAX 3
`define RSC_ST_LP_ON 4
// timing
`define RSC_CLK_KHZ 10000
`define RSC_TICK_KHZ 4
`define RSC_WINDOW_MS 1000
`define RSC_SETTLE_MIN 20
`define RSC_TICK_CYC (`RSC_CLK_KHZ / `RSC_TICK_KHZ)
`define RSC_WINDOW_TICKS (`RSC_WINDOW_MS * `RSC_TICK_KHZ)
`define RSC_SETTLE_WIN (`RSC_SETTLE_MIN * 60 * 1000 / `RSC_WINDOW_MS)
`endif

/* include/rsc_pkg.sv */
`default_nettype none
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_MODE_OFF = 2'h0,
    RSC_MODE_ONCE = 2'h1,
    RSC_MODE_CONT = 2'h2
  } rsc_mode_t;
  typedef enum logic [1:0] {
    RSC_SRCH_IDLE = 2'h0,
    RSC_SRCH_MEASURE = 2'h1,
    RSC_SRCH_APPLY = 2'h3
  } rsc_srch_t;
endpackage
`default_nettype wire

/* rtl/rsc_stage.sv */
`default_nettype none
module rsc_stage (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic is_notch,
  input wire logic [3:0] shift,
  input wire logic [5:0] depth,
  input wire logic in_valid,
  input wire logic signed [15:0] in_data,
  output logic out_valid,
  output logic signed [15:0] out_data
);
  logic signed [23:0] acc;
  wire logic signed [23:0] x_ext = {in_data, 8'h00};
  wire logic signed [23:0] next_acc = acc + ((x_ext - acc) >>> shift);
  wire logic signed [15:0] lp = next_acc[23:8];
  wire logic signed [16:0] resid = 17'(in_data) - 17'(lp);
  wire logic signed [23:0] cut = (24'(resid) * $signed({1'b0, depth})) >>> 5;
  wire logic signed [17:0] notch = 18'(in_data) - 18'(cut);
  wire logic signed [15:0] notch_sat = (notch > 18'sh07FFF) ? 16'sh7FFF :
                                       (notch < -18'sh08000) ? -16'sh8000 : notch[15:0];
  wire logic signed [15:0] filtered = is_notch ? notch_sat : lp;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= 24'h000000;
      out_valid <= 1'b0;
      out_data <= 16'h0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        acc <= enable ? next_acc : x_ext;
        out_data <= enable ? filtered : in_data;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/rsc_top_chk.sv */
`default_nettype none
module rsc_top_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SAMPLE_VALID,
  input wire logic SAMPLE_OUT_VALID,
  input wire logic [15:0] SAMPLE_OUT
);
  localparam logic [11:0] A_LP = 12'h8C8, A_N2F = 12'h958, A_N2D = 12'h960;
  localparam logic [11:0] A_N3F = 12'h968, A_N3D = 12'h970, A_MD = 12'h978, A_ST = 12'h980;
  wire logic rd = PSEL && PENABLE && !PWRITE;
  wire logic dep = PADDR == A_N2D || PADDR == A_N3D;
  wire logic frq = PADDR == A_N2F || PADDR == A_N3F;
  wire logic hit = dep || frq || PADDR == A_LP || PADDR == A_MD || PADDR == A_ST;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_in;
    SAMPLE_VALID;
  endsequence
  sequence s_out;
    ##3 SAMPLE_OUT_VALID;
  endsequence
  a_sample_latency: assert property (s_in |-> s_out)
    else $error("sample output late");
  a_no_extra: assert property (SAMPLE_OUT_VALID |-> $past(SAMPLE_VALID, 3))
    else $error("sample output without input");
  a_out_holds: assert property (!SAMPLE_OUT_VALID |-> $stable(SAMPLE_OUT))
    else $error("sample output moved");
  a_ready_high: assert property (PSEL |-> PREADY)
    else $error("wait state seen");
  a_unmapped_err: assert property (PSEL && PENABLE && !hit |-> PSLVERR)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (rd && hit |-> !PSLVERR)
    else $error("mapped read refused");
  a_depth_range: assert property (rd && dep |-> PRDATA <= 32'h20)
    else $error("depth out of range");
  a_freq_range: assert property (rd && frq |-> PRDATA == 0 || PRDATA inside {[50:2000]})
    else $error("frequency out of range");
  a_lp_range: assert property (rd && PADDR == A_LP |-> PRDATA <= 32'h3E8)
    else $error("lowpass out of range");
  a_mode_range: assert property (rd && PADDR == A_MD |-> PRDATA <= 32'h2)
    else $error("mode out of range");
endmodule
bind rsc_top rsc_top_chk u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_OUT_VALID(SAMPLE_OUT_VALID), .SAMPLE_OUT(SAMPLE_OUT));
`default_nettype wire

/* tb/test_resonance_suppression_ctrl.sv */
`default_nettype none
module test_resonance_suppression_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 1600;
  localparam logic [11:0] A_LP = 12'h8C8, A_N2F = 12'h958, A_N2D = 12'h960;
  localparam logic [11:0] A_N3F = 12'h968, A_N3D = 12'h970, A_MD = 12'h978, A_ST = 12'h980;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic HIGH_POWER_MODEL = 1'b0;
  logic SAMPLE_VALID = 1'b0;
  logic [15:0] SAMPLE_IN = 16'h0000;
  logic SAMPLE_OUT_VALID;
  logic [15:0] SAMPLE_OUT;
  logic wave_on = 1'b0;
  logic [3:0] wave_cnt = 4'h0;
  logic [31:0] rdv;
  logic [15:0] so;
  logic errv;
  logic clr;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  rsc_top #(.TICK_CYC(4), .WINDOW_TICKS(400), .SETTLE_WIN(2)) u_dut (.CLK(CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HIGH_POWER_MODEL(HIGH_POWER_MODEL),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_IN(SAMPLE_IN), .SAMPLE_OUT_VALID(SAMPLE_OUT_VALID),
    .SAMPLE_OUT(SAMPLE_OUT));
  initial begin
    forever #50 CLK = ~CLK;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // square wave of 100 Hz at the shortened window length
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (wave_on) begin
      wave_cnt <= wave_cnt + 4'h1;
      SAMPLE_VALID <= 1'b1;
      SAMPLE_IN <= wave_cnt[3] ? 16'h3000 : 16'hD000;
    end
    if (cycles == 40000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rdv = PRDATA;
    errv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("slave error", {31'h0, e}, {31'h0, errv});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdv);
  endtask
  task automatic send(input logic [15:0] v);
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_IN <= v;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
    so = SAMPLE_OUT;
  endtask
  task automatic reset_dut(input logic hp);
    HIGH_POWER_MODEL <= hp;
    RST <= 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  initial begin
    reset_dut(1'b0);
    rd(A_LP, 32'h2, "lowpass default");
    rd(A_N2F, 32'h3E8, "n2 freq default");
    rd(A_N2D, 32'h0, "n2 depth default");
    rd(A_N3F, 32'h3E8, "n3 freq default");
    rd(A_N3D, 32'h0, "n3 depth default");
    rd(A_MD, 32'h0, "mode default");
    reset_dut(1'b1);
    rd(A_LP, 32'h5, "lowpass large model");
    wr(A_N3F, 32'h9C4, 1'b0);
    rd(A_N3F, 32'h7D0, "n3 freq high clamp");
    wr(A_N3F, 32'hA, 1'b0);
    rd(A_N3F, 32'h32, "n3 freq low clamp");
    wr(A_N3F, 32'h0, 1'b0);
    rd(A_N3F, 32'h0, "n3 freq off");
    wr(A_N2D, 32'hFFFF0028, 1'b0);
    rd(A_N2D, 32'h20, "n2 depth clamp");
    rd(A_ST, 32'h1A, "status at max");
    wr(A_LP, 32'h5DC, 1'b0);
    rd(A_LP, 32'h3E8, "lowpass clamp");
    wr(A_ST, 32'h0, 1'b1);
    wr(12'h004, 32'h1, 1'b1);
    wr(A_N3D, 32'h14, 1'b0);
    wr(A_N2F, 32'h1F4, 1'b0);
    wr(A_N2D, 32'h0, 1'b0);
    wr(A_LP, 32'h0, 1'b0);
    rd(A_ST, 32'h0, "status all off");
    send(16'h8001);
    chk("bypass", 32'h8001, {16'h0, so});
    send(16'h7FFF);
    chk("bypass", 32'h7FFF, {16'h0, so});
    wr(A_N3F, 32'h320, 1'b0);
    rd(A_ST, 32'h4, "status n3 on");
    wr(A_N3D, 32'h0, 1'b0);
    rd(A_ST, 32'h0, "status n3 off");
    wr(A_LP, 32'h3E8, 1'b0);
    send(16'h4000);
    chk("lowpass acts", 32'h1, {31'h0, so !== 16'h4000});
    for (int f = 0; f < 3; f++) begin
      for (int t = 0; t < 3; t++) begin
        wr(A_MD, 32'h0, 1'b0);
        if (f != 0) wr(A_MD, 32'(f), 1'b0);
        wr(A_N2F, 32'h1F4, 1'b0);
        wr(A_N2D, 32'hA, 1'b0);
        wr(A_N3F, 32'h2BC, 1'b0);
        wr(A_N3D, 32'hC, 1'b0);
        wr(A_MD, 32'(t), 1'b0);
        clr = (t == 1) || (t == 2 && f == 0);
        rd(A_N2F, clr ? 32'h3E8 : 32'h1F4, "n2 freq");
        rd(A_N2D, clr ? 32'h0 : 32'hA, "n2 depth");
        rd(A_N3F, clr ? 32'h3E8 : 32'h2BC, "n3 freq");
        rd(A_N3D, clr ? 32'h0 : 32'hC, "n3 depth");
        rd(A_MD, 32'(t), "mode");
      end
    end
    wr(A_MD, 32'h3, 1'b0);
    rd(A_MD, 32'h2, "bad mode ignored");
    wr(A_MD, 32'h1, 1'b0);
    wave_on <= 1'b1;
    repeat (3 * WC) @(posedge CLK);
    apb(1'b0, A_N2D, 32'h0);
    chk_rng("found depth", 2, 32, rdv);
    apb(1'b0, A_N2F, 32'h0);
    chk_rng("found freq", WC / 16 - 10, WC / 16 + 5, rdv);
    rd(A_MD, 32'h1, "mode while found");
    wr(A_MD, 32'h0, 1'b0);
    apb(1'b0, A_N2D, 32'h0);
    so = rdv[15:0];
    repeat (2 * WC) @(posedge CLK);
    rd(A_N2D, {16'h0, so}, "depth kept");
    wave_on <= 1'b0;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    wr(A_MD, 32'h1, 1'b0);
    rd(A_MD, 32'h1, "mode once");
    repeat (4 * WC) @(posedge CLK);
    rd(A_MD, 32'h0, "mode settled");
    wr(A_MD, 32'h2, 1'b0);
    repeat (4 * WC) @(posedge CLK);
    rd(A_MD, 32'h2, "mode endless");
    rd(A_ST, 32'h11, "status searching");
    summarize();
  end
endmodule
`default_nettype wire
